// file: hw/cmd_decoder.sv
/*
  Command bus decoder: turns sampled control pins into one command
  per clock edge, with bank, address and mode register select.
  Assumes the controller drives pins asynchronously to clk_sys; they
  are synchronised here, so results trail the pins by three edges.
*/
module cmd_decoder
  import cmd_decode_pkg::*;
#(
  parameter int BW = BANK_W,
  parameter int AW = ADDR_W
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          cke,
  input  wire logic          cs_n,
  input  wire logic          ras_n,
  input  wire logic          cas_n,
  input  wire logic          we_n,
  input  wire logic [BW-1:0] bank,
  input  wire logic [AW-1:0] addr,
  output cmd_t               cmd_ff,
  output logic               cmd_valid_ff,
  output logic               illegal_ff,
  output logic [BW-1:0]      bank_ff,
  output logic [AW-1:0]      addr_ff,
  output logic               mode_wr_ff,
  output logic [BW-1:0]      mode_sel_ff,
  output logic               sref_ff,
  output logic               sref_exit_req_ff
);

  localparam int PW = 5 + BW + AW;

  // ==========================================================================
  // Pin capture
  logic [PW-1:0] pins_s;
  logic          cke_s;
  logic          cs_n_s;
  logic          ras_n_s;
  logic          cas_n_s;
  logic          we_n_s;
  logic [BW-1:0] bank_s;
  logic [AW-1:0] addr_s;
  logic          cke_prev_ff;
  logic          sref_exit_raw;

  // Idle bus at reset: CKE low, all strobes high
  pin_sync #(
    .WIDTH   (PW),
    .RST_VAL ({1'b0, 4'hf, {(BW + AW){1'b0}}})
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     ({cke, cs_n, ras_n, cas_n, we_n, bank, addr}),
    .dout    (pins_s)
  );

  assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, bank_s, addr_s} = pins_s;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cke_prev_ff <= 1'b0;
    end else begin
      cke_prev_ff <= cke_s;
    end
  end

  // ==========================================================================
  // Self refresh exit
  // CKE rising is the exit; a toggle clocked by the pin records it even
  // while the system clock is gated. Toggling on every rise keeps clk_sys
  // state out of the CKE domain; sref_ff qualifies it on the clk_sys side.
  always_ff @(posedge cke or negedge rst_b) begin
    if (!rst_b) begin
      sref_exit_raw <= 1'b0;
    end else begin
      sref_exit_raw <= ~sref_exit_raw;
    end
  end

  logic sref_exit_s;
  pin_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_exit_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     (sref_exit_raw),
    .dout    (sref_exit_s)
  );

  // Last synced toggle level; a difference marks one new CKE rise
  logic sref_exit_seen_ff;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sref_exit_seen_ff <= 1'b0;
      sref_exit_req_ff  <= 1'b0;
    end else begin
      sref_exit_seen_ff <= sref_exit_s;
      sref_exit_req_ff  <= (sref_exit_s ^ sref_exit_seen_ff)
                           & sref_ff;
    end
  end

  // ==========================================================================
  // Decode
  cmd_t nxt_cmd;
  logic idle_pins;
  assign idle_pins = cs_n_s | (ras_n_s & cas_n_s & we_n_s);

  always_comb begin
    nxt_cmd = CMD_ILLEGAL;
    if (cke_prev_ff) begin
      if (cs_n_s) begin
        nxt_cmd = cke_s ? CMD_DESELECT : CMD_PDN_ENTRY;
      end else if (ras_n_s & cas_n_s & we_n_s) begin
        nxt_cmd = cke_s ? CMD_NOP : CMD_PDN_ENTRY;
      end else if (!cke_s) begin
        if (!ras_n_s && !cas_n_s && we_n_s) begin
          nxt_cmd = CMD_SREF_ENTRY;
        end
      end else begin
        unique case ({ras_n_s, cas_n_s, we_n_s})
          3'b000: nxt_cmd = CMD_LOAD_MODE;
          3'b001: nxt_cmd = CMD_REFRESH;
          3'b010: nxt_cmd = addr_s[AP_BIT] ? CMD_PRE_ALL
                                           : CMD_PRE_BANK;
          3'b011: nxt_cmd = CMD_ACTIVATE;
          3'b100: nxt_cmd = addr_s[AP_BIT] ? CMD_WRITE_AP
                                           : CMD_WRITE;
          3'b101: nxt_cmd = addr_s[AP_BIT] ? CMD_READ_AP
                                           : CMD_READ;
          default: nxt_cmd = CMD_ILLEGAL;
        endcase
      end
    end else if (cke_s && idle_pins) begin
      nxt_cmd = sref_ff ? CMD_SREF_EXIT : CMD_PDN_EXIT;
    end else if (!cke_s) begin
      nxt_cmd = CMD_NOP; // Clock held off: CMD_NOP is registered
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff       <= cmd_t'(CMD_RESET_VAL);
      cmd_valid_ff <= 1'b0;
      illegal_ff   <= 1'b0;
      bank_ff      <= '0;
      addr_ff      <= '0;
    end else begin
      cmd_ff       <= nxt_cmd;
      cmd_valid_ff <= 1'b1;
      illegal_ff   <= (nxt_cmd == CMD_ILLEGAL);
      bank_ff      <= bank_s;
      addr_ff      <= addr_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_wr_ff  <= 1'b0;
      mode_sel_ff <= '0;
    end else begin
      mode_wr_ff <= (nxt_cmd == CMD_LOAD_MODE);
      if (nxt_cmd == CMD_LOAD_MODE) begin
        mode_sel_ff <= bank_s;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sref_ff <= 1'b0;
    end else if (nxt_cmd == CMD_SREF_ENTRY) begin
      sref_ff <= 1'b1;
    end else if (nxt_cmd == CMD_SREF_EXIT) begin
      sref_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  AST_LOAD_MODE: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (cke_prev_ff && cke_s && !cs_n_s && !ras_n_s && !cas_n_s && !we_n_s)
    |=> (cmd_ff == CMD_LOAD_MODE && mode_wr_ff
         && mode_sel_ff == $past(bank_s)))
    else $error("Load mode not decoded");

  AST_REFRESH: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (cke_prev_ff && cke_s && !cs_n_s && !ras_n_s && !cas_n_s && we_n_s)
    |=> cmd_ff == CMD_REFRESH)
    else $error("Refresh not decoded");

  AST_PRECHARGE: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (cke_prev_ff && cke_s && !cs_n_s && !ras_n_s && cas_n_s && !we_n_s)
    |=> cmd_ff == ($past(addr_s[AP_BIT]) ? CMD_PRE_ALL : CMD_PRE_BANK))
    else $error("Precharge misdecoded");

  AST_WRITE: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (cke_prev_ff && cke_s && !cs_n_s && ras_n_s && !cas_n_s && !we_n_s)
    |=> cmd_ff == ($past(addr_s[AP_BIT]) ? CMD_WRITE_AP : CMD_WRITE))
    else $error("Write misdecoded");

  AST_READ: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (cke_prev_ff && cke_s && !cs_n_s && ras_n_s && !cas_n_s && we_n_s)
    |=> cmd_ff == ($past(addr_s[AP_BIT]) ? CMD_READ_AP : CMD_READ))
    else $error("Read misdecoded");

  AST_SREF_ENTRY: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (cke_prev_ff && !cke_s && !cs_n_s && !ras_n_s && !cas_n_s && we_n_s)
    |=> (cmd_ff == CMD_SREF_ENTRY) ##1 sref_ff)
    else $error("Self refresh entry missed");

  AST_DESELECT: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (cke_prev_ff && cke_s && cs_n_s) |=> cmd_ff == CMD_DESELECT)
    else $error("Deselect misdecoded");

  AST_ILLEGAL: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    illegal_ff |-> (!mode_wr_ff && cmd_ff == CMD_ILLEGAL))
    else $error("Illegal combination started an operation");

  // Pin toggle and synced CKE travel equal depth, so both land together
  AST_SREF_EXIT_REQ: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (!cke_prev_ff && cke_s && idle_pins && sref_ff) |=> sref_exit_req_ff)
    else $error("Self refresh exit request missed");

endmodule : cmd_decoder

// file: hw/cmd_decode_pkg.sv
/*
  Constants and command enumeration for the command bus decoder.
  Assumes pins asynchronous to clk_sys, sampled on its rising edge.
*/
package cmd_decode_pkg;

  // ==========================================================================
  // Bus widths
  localparam int BANK_W = 3;
  localparam int ADDR_W = 14;
  localparam int AP_BIT = 10;

  // ==========================================================================
  // Command codes
  typedef enum logic [3:0] {
    CMD_DESELECT,
    CMD_NOP,
    CMD_LOAD_MODE,
    CMD_REFRESH,
    CMD_SREF_ENTRY,
    CMD_SREF_EXIT,
    CMD_PRE_BANK,
    CMD_PRE_ALL,
    CMD_ACTIVATE,
    CMD_WRITE,
    CMD_WRITE_AP,
    CMD_READ,
    CMD_READ_AP,
    CMD_PDN_ENTRY,
    CMD_PDN_EXIT,
    CMD_ILLEGAL
  } cmd_t;

  localparam logic [3:0] CMD_RESET_VAL = 4'h0;

endpackage : cmd_decode_pkg

// file: hw/pin_sync.sv
/*
  Two-flop synchroniser for a bundle of levels.
  Assumes inputs come from outside the clk_sys domain.
*/
module pin_sync #(
  parameter int            WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // ==========================================================================
  // Synchroniser chain
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule : pin_sync

// file: tb/ctrl_model.sv
/*
  Memory controller model driving the command bus of the decoder.
  Assumes the bench calls issue once per command, from one process.
*/
module ctrl_model
  import cmd_decode_pkg::*;
(
  input  wire logic              clk_sys,
  output logic                   cke,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic [BANK_W-1:0]      bank,
  output logic [ADDR_W-1:0]      addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    bank = '0;
    addr = '0;
  end

  // ==========================================================================
  // One cycle of prior CKE, one command cycle, then NOP
  // Address lines flip after the command so stale values never match
  task automatic issue(input logic pc, input logic c, input logic [3:0] p,
                       input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    cke <= pc;
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    @(posedge clk_sys);
    cke <= c;
    {cs_n, ras_n, cas_n, we_n} <= p;
    bank <= b;
    addr <= a;
    @(posedge clk_sys);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    bank <= ~b;
    addr <= ~a;
  endtask : issue
endmodule : ctrl_model

// file: tb/ddr2_command_decoder_bench.sv
/*
  Self-checking bench for the command decoder.
  Assumes three edges from pins to decoded outputs.
*/
module ddr2_command_decoder_bench
  import cmd_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys;
  logic              rst_b;
  logic              cke, cs_n, ras_n, cas_n, we_n;
  logic [BANK_W-1:0] bank, bank_ff, mode_sel_ff;
  logic [ADDR_W-1:0] addr, addr_ff;
  cmd_t              cmd_ff;
  logic              cmd_valid_ff, illegal_ff, mode_wr_ff;
  logic              sref_ff, sref_exit_req_ff;
  int                mismatches;
  int                check_count;

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  ctrl_model u_ctrl_model (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr));

  cmd_decoder u_cmd_decoder (.clk_sys(clk_sys), .rst_b(rst_b), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank(bank),
    .addr(addr), .cmd_ff(cmd_ff), .cmd_valid_ff(cmd_valid_ff),
    .illegal_ff(illegal_ff), .bank_ff(bank_ff), .addr_ff(addr_ff),
    .mode_wr_ff(mode_wr_ff), .mode_sel_ff(mode_sel_ff), .sref_ff(sref_ff),
    .sref_exit_req_ff(sref_exit_req_ff));

  // ==========================================================================
  // Checking helpers
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic expect_cmd(input logic pc, input logic c,
                            input logic [3:0] p, input logic [2:0] b,
                            input logic [13:0] a, input cmd_t e,
                            input logic chk_ad);
    u_ctrl_model.issue(pc, c, p, b, a);
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    cmp(cmd_ff, e);
    cmp(illegal_ff, e == CMD_ILLEGAL);
    cmp(mode_wr_ff, e == CMD_LOAD_MODE);
    if (chk_ad) begin
      cmp(bank_ff, b);
      cmp(addr_ff, a);
    end
  endtask : expect_cmd

  // ==========================================================================
  // Scenarios
  task automatic t_mode_refresh();
    expect_cmd(1, 1, 4'h0, 3'h2, 14'h0123, CMD_LOAD_MODE, 1);
    cmp(mode_sel_ff, 3'h2);
    expect_cmd(1, 1, 4'h1, 3'h5, 14'h0456, CMD_REFRESH, 0);
  endtask : t_mode_refresh

  task automatic t_row();
    expect_cmd(1, 1, 4'h3, 3'h5, 14'h1abc, CMD_ACTIVATE, 1);
    expect_cmd(1, 1, 4'h2, 3'h7, 14'h3bff, CMD_PRE_BANK, 1);
    expect_cmd(1, 1, 4'h2, 3'h1, 14'h0400, CMD_PRE_ALL, 0);
  endtask : t_row

  task automatic t_column();
    expect_cmd(1, 1, 4'h4, 3'h3, 14'h03f8, CMD_WRITE, 1);
    expect_cmd(1, 1, 4'h4, 3'h4, 14'h0407, CMD_WRITE_AP, 1);
    expect_cmd(1, 1, 4'h5, 3'h6, 14'h3bf0, CMD_READ, 1);
    expect_cmd(1, 1, 4'h5, 3'h0, 14'h0401, CMD_READ_AP, 1);
  endtask : t_column

  task automatic t_idle_illegal();
    expect_cmd(1, 1, 4'h7, 3'h0, 14'h0000, CMD_NOP, 0);
    expect_cmd(1, 1, 4'h8, 3'h0, 14'h0000, CMD_DESELECT, 0);
    expect_cmd(1, 1, 4'hb, 3'h0, 14'h0000, CMD_DESELECT, 0);
    expect_cmd(1, 1, 4'h6, 3'h1, 14'h0010, CMD_ILLEGAL, 0);
  endtask : t_idle_illegal

  task automatic t_power();
    expect_cmd(1, 0, 4'h7, 3'h0, 14'h0000, CMD_PDN_ENTRY, 0);
    expect_cmd(0, 1, 4'h8, 3'h0, 14'h0000, CMD_PDN_EXIT, 0);
    cmp(sref_exit_req_ff, 1'b0);
    expect_cmd(1, 0, 4'h8, 3'h0, 14'h0000, CMD_PDN_ENTRY, 0);
  endtask : t_power

  task automatic t_sref();
    expect_cmd(1, 0, 4'h1, 3'h0, 14'h0000, CMD_SREF_ENTRY, 0);
    @(posedge clk_sys);
    #1;
    cmp(sref_ff, 1'b1);
    expect_cmd(0, 1, 4'h7, 3'h0, 14'h0000, CMD_SREF_EXIT, 0);
    cmp(sref_exit_req_ff, 1'b1);
    cmp(sref_ff, 1'b0);
  endtask : t_sref

  // Mid-run reset while in self refresh, then release
  task automatic t_reset();
    expect_cmd(1, 0, 4'h1, 3'h0, 14'h0000, CMD_SREF_ENTRY, 0);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    #1;
    cmp(cmd_ff, CMD_DESELECT);
    cmp({cmd_valid_ff, sref_ff}, 2'h0);
    cmp({illegal_ff, sref_exit_req_ff}, 2'h0);
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    cmp(cmd_valid_ff, 1'b1);
    cmp(cmd_ff, CMD_NOP);
  endtask : t_reset

  // ==========================================================================
  // Verdict, reached from one place only
  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    mismatches = 0;
    check_count = 0;
    rst_b = 1'b0;
    #1;
    cmp(cmd_ff, CMD_DESELECT);
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_mode_refresh();
    t_row();
    t_column();
    t_idle_illegal();
    t_power();
    t_sref();
    t_reset();
    report_and_stop();
  end
endmodule : ddr2_command_decoder_bench
